//--- hdl/coa_operand_unit.sv
`timescale 1ns/100ps
module coa_operand_unit
  import coa_pkg::*;
(
  input  wire logic                    core_clk,
  input  wire logic                    sys_rst,
  input  wire logic                    instr_valid,
  output logic                         instr_ready,
  input  wire coa_pkg::coa_instr_type  instr,
  output coa_pkg::coa_mem_req_type     mem_req,
  input  wire logic [7:0]              mem_rdata,
  output logic [1:0]                   instr_length,
  output logic                         instr_done,
  output logic [7:0]                   acc,
  output logic [7:0]                   index_reg,
  output logic [7:0]                   flags,
  output logic [7:0]                   stack_pointer
);
  import coa_pkg::*;

  // ****************************************************************
  // sequencer: address, read the location, then write back
  // ****************************************************************
  typedef enum logic [1:0] {
    COA_IDLE  = 2'b00,
    COA_READ  = 2'b01,
    COA_WRITE = 2'b11
  } coa_state_type;

  coa_state_type state;
  coa_state_type next_state;
  coa_instr_type cur;
  logic [7:0]    rd_data;
  logic [7:0]    eff_addr;
  logic [7:0]    src_val;
  logic [7:0]    second_val;
  logic [7:0]    alu_result;
  logic          alu_carry;
  logic          is_src_mode;
  logic          uses_mem;
  logic          mem_dst;
  logic          wb_now;

  function automatic logic mode_indexed(input coa_mode_type m);
    return (m == COA_SRC_IDX) || (m == COA_DST_IDX) || (m == COA_DST_IDX_IMM);
  endfunction

  function automatic logic mode_src(input coa_mode_type m);
    return (m == COA_SRC_IMM) || (m == COA_SRC_DIR) || (m == COA_SRC_IDX);
  endfunction

  function automatic logic [7:0] reg_value(input coa_reg_type r, input logic [7:0] a,
                                           input logic [7:0] x, input logic [7:0] f,
                                           input logic [7:0] s);
    logic [7:0] v;
    v = a;
    unique case (r)
      COA_REG_ACC:   v = a;
      COA_REG_INDEX: v = x;
      COA_REG_FLAGS: v = f;
      COA_REG_STACK: v = s;
    endcase
    return v;
  endfunction

  assign instr_ready = (state == COA_IDLE);
  assign is_src_mode = mode_src(cur.mode);
  assign uses_mem    = (cur.mode != COA_SRC_IMM);
  assign mem_dst     = !is_src_mode;

  // truncated sum wraps inside the 256-location space
  assign eff_addr = mode_indexed(cur.mode) ?
                    8'(cur.operand1 + index_reg) : cur.operand1;

  always_comb begin
    src_val    = cur.operand1;
    second_val = reg_value(cur.core_reg, acc, index_reg, flags, stack_pointer);
    unique case (cur.mode)
      COA_SRC_IMM: src_val = cur.operand1;
      COA_SRC_DIR, COA_SRC_IDX: src_val = rd_data;
      COA_DST_DIR: begin
        src_val    = reg_value(cur.core_reg, acc, index_reg, flags, stack_pointer);
        second_val = rd_data;
      end
      COA_DST_IDX: begin
        src_val    = acc;
        second_val = rd_data;
      end
      COA_DST_DIR_IMM, COA_DST_IDX_IMM: begin
        src_val    = cur.operand2;
        second_val = rd_data;
      end
      default: src_val = cur.operand1;
    endcase
  end

  coa_alu u_alu (
    .op     (cur.op),
    .src    (src_val),
    .second (second_val),
    .result (alu_result),
    .carry  (alu_carry)
  );

  // ****************************************************************
  // state
  // ****************************************************************
  always_comb begin
    next_state = state;
    unique case (state)
      COA_IDLE:  if (instr_valid) next_state = COA_READ;
      COA_READ:  next_state = COA_WRITE;
      COA_WRITE: next_state = COA_IDLE;
      default:   next_state = COA_IDLE;
    endcase
  end

  always_ff @(posedge core_clk) begin
    if (sys_rst) begin
      state <= COA_IDLE;
    end else begin
      state <= next_state;
    end
  end

  always_ff @(posedge core_clk) begin
    if (sys_rst) begin
      cur <= '0;
    end else if (instr_valid && instr_ready) begin
      cur <= instr;
    end
  end

  always_ff @(posedge core_clk) begin
    if (sys_rst) begin
      rd_data <= COA_BYTE_RESET;
    end else if (state == COA_READ) begin
      rd_data <= mem_rdata;
    end
  end

  assign wb_now = (state == COA_WRITE);

  // ****************************************************************
  // memory request: read in the read state, write only for destinations
  // ****************************************************************
  always_ff @(posedge core_clk) begin
    if (sys_rst) begin
      mem_req <= '0;
    end else begin
      // the write leaves at the end of the write state, once the read byte is latched
      mem_req.valid     <= (next_state == COA_READ && instr_valid && state == COA_IDLE &&
                            instr.mode != COA_SRC_IMM) ||
                           (wb_now && mem_dst);
      mem_req.write     <= wb_now && mem_dst;
      mem_req.reg_space <= (state == COA_IDLE) ? instr.reg_space : cur.reg_space;
      mem_req.bank      <= flags[COA_BANK_BIT];
      mem_req.addr      <= (state == COA_IDLE) ?
                           (mode_indexed(instr.mode) ? 8'(instr.operand1 + index_reg)
                                                     : instr.operand1)
                           : eff_addr;
      mem_req.wdata     <= alu_result;
    end
  end

  always_ff @(posedge core_clk) begin
    if (sys_rst) begin
      instr_length <= COA_LEN_TWO;
      instr_done   <= 1'b0;
    end else begin
      instr_done <= wb_now;
      if (wb_now) begin
        instr_length <= (cur.mode == COA_DST_DIR_IMM || cur.mode == COA_DST_IDX_IMM) ?
                        COA_LEN_THREE : COA_LEN_TWO;
      end
    end
  end

  // ****************************************************************
  // core registers, written only by source modes, except the zero and carry flags, which destination modes also update
  // ****************************************************************
  always_ff @(posedge core_clk) begin
    if (sys_rst) begin
      acc <= COA_BYTE_RESET;
    end else if (wb_now && is_src_mode && cur.core_reg == COA_REG_ACC) begin
      acc <= alu_result;
    end
  end

  always_ff @(posedge core_clk) begin
    if (sys_rst) begin
      index_reg <= COA_BYTE_RESET;
    end else if (wb_now && is_src_mode && cur.core_reg == COA_REG_INDEX) begin
      index_reg <= alu_result;
    end
  end

  always_ff @(posedge core_clk) begin
    if (sys_rst) begin
      stack_pointer <= COA_BYTE_RESET;
    end else if (wb_now && cur.mode == COA_SRC_IMM && cur.core_reg == COA_REG_STACK) begin
      stack_pointer <= alu_result;
    end
  end

  // flags: only immediate-mode ops (any op) target it; bit 3 and reserved bits stay
  always_ff @(posedge core_clk) begin
    if (sys_rst) begin
      flags <= COA_FLAGS_RESET;
    end else if (wb_now && cur.mode == COA_SRC_IMM && cur.core_reg == COA_REG_FLAGS) begin
      flags <= (flags & ~COA_FLAGS_WMASK) | (alu_result & COA_FLAGS_WMASK);
    end else if (wb_now && cur.op != COA_OP_COPY) begin
      flags[COA_ZERO_BIT] <= (alu_result == 8'h00);
      if (cur.op == COA_OP_ADD) begin
        flags[COA_CARRY_BIT] <= alu_carry;
      end
    end
  end

  // ****************************************************************
  // checks
  // ****************************************************************
  a_acc_kept_dst: assert property (@(posedge core_clk) disable iff (sys_rst)
    (wb_now && mem_dst) |=> $stable(acc))
    else $error("accumulator changed by memory destination");

  a_src_no_write: assert property (@(posedge core_clk) disable iff (sys_rst)
    (wb_now && is_src_mode) |=> !mem_req.write)
    else $error("source mode wrote memory");

  a_read_issued: assert property (@(posedge core_clk) disable iff (sys_rst)
    (state == COA_READ) |-> (mem_req.valid == uses_mem && !mem_req.write))
    else $error("location read missing in read state");

  a_dst_writes: assert property (@(posedge core_clk) disable iff (sys_rst)
    (wb_now && mem_dst) |=>
      (mem_req.write && mem_req.valid && mem_req.addr == $past(eff_addr)))
    else $error("destination not written at its address");

  a_dst_add: assert property (@(posedge core_clk) disable iff (sys_rst)
    (wb_now && cur.mode == COA_DST_DIR && cur.op == COA_OP_ADD &&
     cur.core_reg == COA_REG_ACC) |=> mem_req.wdata == 8'($past(acc) + $past(rd_data)))
    else $error("direct destination sum wrong");

  a_dst_imm_copy: assert property (@(posedge core_clk) disable iff (sys_rst)
    (wb_now && cur.op == COA_OP_COPY &&
     (cur.mode == COA_DST_DIR_IMM || cur.mode == COA_DST_IDX_IMM)) |=>
      mem_req.wdata == $past(cur.operand2))
    else $error("immediate not written to destination");

  a_idx_wrap: assert property (@(posedge core_clk) disable iff (sys_rst)
    (state == COA_READ && mode_indexed(cur.mode)) |->
      mem_req.addr == 8'(cur.operand1 + index_reg))
    else $error("indexed address wrong");

  a_len_three: assert property (@(posedge core_clk) disable iff (sys_rst)
    (wb_now && (cur.mode == COA_DST_DIR_IMM || cur.mode == COA_DST_IDX_IMM))
      |=> instr_length == COA_LEN_THREE)
    else $error("three byte length missing");

  a_len_two: assert property (@(posedge core_clk) disable iff (sys_rst)
    (wb_now && !(cur.mode == COA_DST_DIR_IMM || cur.mode == COA_DST_IDX_IMM))
      |=> instr_length == COA_LEN_TWO)
    else $error("two byte length missing");

  a_done_pulse: assert property (@(posedge core_clk) disable iff (sys_rst)
    instr_done |=> !instr_done)
    else $error("done longer than one cycle");

  a_sp_imm_only: assert property (@(posedge core_clk) disable iff (sys_rst)
    (wb_now && cur.mode != COA_SRC_IMM) |=> $stable(stack_pointer))
    else $error("stack pointer written outside immediate mode");

  a_bank_steer: assert property (@(posedge core_clk) disable iff (sys_rst)
    mem_req.valid |-> mem_req.bank == $past(flags[COA_BANK_BIT]))
    else $error("bank does not follow flags");

  a_flags_and: assert property (@(posedge core_clk) disable iff (sys_rst)
    (wb_now && cur.mode == COA_SRC_IMM && cur.core_reg == COA_REG_FLAGS &&
     cur.op == COA_OP_AND) |=>
      flags[COA_BANK_BIT] == ($past(flags[COA_BANK_BIT]) & $past(cur.operand1[COA_BANK_BIT])))
    else $error("flags and wrong");

  a_index_load: assert property (@(posedge core_clk) disable iff (sys_rst)
    (wb_now && cur.mode == COA_SRC_DIR && cur.op == COA_OP_COPY &&
     cur.core_reg == COA_REG_INDEX) |=> index_reg == $past(rd_data))
    else $error("direct load to index failed");

endmodule

//--- hdl/coa_pkg.sv
package coa_pkg;

  // ****************************************************************
  // addressing modes
  // ****************************************************************
  typedef enum logic [2:0] {
    COA_SRC_IMM     = 3'h0,
    COA_SRC_DIR     = 3'h1,
    COA_SRC_IDX     = 3'h2,
    COA_DST_DIR     = 3'h3,
    COA_DST_IDX     = 3'h4,
    COA_DST_DIR_IMM = 3'h5,
    COA_DST_IDX_IMM = 3'h6
  } coa_mode_type;

  typedef enum logic [1:0] {
    COA_REG_ACC   = 2'h0,
    COA_REG_INDEX = 2'h1,
    COA_REG_FLAGS = 2'h2,
    COA_REG_STACK = 2'h3
  } coa_reg_type;

  typedef enum logic [2:0] {
    COA_OP_COPY = 3'h0,
    COA_OP_ADD  = 3'h1,
    COA_OP_AND  = 3'h2,
    COA_OP_OR   = 3'h3,
    COA_OP_XOR  = 3'h4
  } coa_op_type;

  // decoded instruction from the fetch path
  typedef struct packed {
    coa_mode_type mode;
    coa_op_type   op;
    coa_reg_type  core_reg;
    logic         reg_space;
    logic [7:0]   operand1;
    logic [7:0]   operand2;
  } coa_instr_type;

  // one access to ram or register space
  typedef struct packed {
    logic       valid;
    logic       write;
    logic       reg_space;
    logic       bank;
    logic [7:0] addr;
    logic [7:0] wdata;
  } coa_mem_req_type;

  // ****************************************************************
  // constants
  // ****************************************************************
  localparam logic [1:0] COA_LEN_TWO      = 2'h2;
  localparam logic [1:0] COA_LEN_THREE    = 2'h3;
  localparam int         COA_BANK_BIT     = 4;
  localparam int         COA_CARRY_BIT    = 2;
  localparam int         COA_ZERO_BIT     = 1;
  localparam logic [7:0] COA_FLAGS_RESET  = 8'h02;
  localparam logic [7:0] COA_FLAGS_WMASK  = 8'h17;
  localparam logic [7:0] COA_BYTE_RESET   = 8'h00;

endpackage

//--- hdl/coa_alu.sv
`timescale 1ns/100ps
module coa_alu
  import coa_pkg::*;
(
  input  coa_pkg::coa_op_type op,
  input  logic [7:0]          src,
  input  logic [7:0]          second,
  output logic [7:0]          result,
  output logic                carry
);

  logic [8:0] sum;

  always_comb begin
    sum    = {1'b0, src} + {1'b0, second};
    carry  = 1'b0;
    result = src;
    unique case (op)
      COA_OP_COPY: result = src;
      COA_OP_ADD: begin
        result = sum[7:0];
        carry  = sum[8];
      end
      COA_OP_AND: result = src & second;
      COA_OP_OR:  result = src | second;
      COA_OP_XOR: result = src ^ second;
      default:    result = src;
    endcase
  end

endmodule

//--- tb/coa_mem_model.sv
`timescale 1ns/100ps
module coa_mem_model (
  input  wire logic                     core_clk,
  input  wire coa_pkg::coa_mem_req_type mem_req,
  output logic [7:0]                    mem_rdata
);
  import coa_pkg::*;

  logic [7:0] ram  [256];
  logic [7:0] regs [2][256];
  logic [7:0] last = 8'h00;
  logic [7:0] pick;
  logic       rd;

  // ********************
  // data ram and register banks
  // ********************
  assign rd = mem_req.valid && !mem_req.write;

  always_comb begin
    pick = mem_req.reg_space ? regs[mem_req.bank][mem_req.addr] : ram[mem_req.addr];
  end

  // an idle bus shows the inverse of the last read, so stale data never looks valid
  assign mem_rdata = rd ? pick : ~last;

  // plain always: the bench preloads the arrays as well
  always @(posedge core_clk) begin
    if (rd) begin
      last <= pick;
    end
    if (mem_req.valid && mem_req.write) begin
      if (mem_req.reg_space) begin
        regs[mem_req.bank][mem_req.addr] <= mem_req.wdata;
      end else begin
        ram[mem_req.addr] <= mem_req.wdata;
      end
    end
  end
endmodule

//--- tb/cpu_operand_addressing_test.sv
`timescale 1ns/100ps
module cpu_operand_addressing_test;
  import coa_pkg::*;

  logic                   core_clk = 1'b0;
  logic                   sys_rst = 1'b1;
  logic                   instr_valid = 1'b0;
  logic                   instr_ready;
  coa_instr_type          instr = '0;
  coa_mem_req_type        mem_req;
  logic [7:0]             mem_rdata;
  logic [1:0]             instr_length;
  logic                   instr_done;
  logic [7:0]             acc;
  logic [7:0]             index_reg;
  logic [7:0]             flags;
  logic [7:0]             stack_pointer;
  int                     failures = 0;
  int                     total_checks = 0;

  always #20 core_clk = ~core_clk;

  coa_operand_unit i_dut (
    .core_clk      (core_clk),
    .sys_rst       (sys_rst),
    .instr_valid   (instr_valid),
    .instr_ready   (instr_ready),
    .instr         (instr),
    .mem_req       (mem_req),
    .mem_rdata     (mem_rdata),
    .instr_length  (instr_length),
    .instr_done    (instr_done),
    .acc           (acc),
    .index_reg     (index_reg),
    .flags         (flags),
    .stack_pointer (stack_pointer)
  );

  coa_mem_model i_mem (
    .core_clk  (core_clk),
    .mem_req   (mem_req),
    .mem_rdata (mem_rdata)
  );

  // ********************
  // shared tasks
  // ********************
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    total_checks++;
    if (got !== exp) begin
      failures++;
      $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task automatic give_verdict();
    if (failures == 0 && total_checks > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask

  // offer one instruction, wait for its end and for the memory write to land
  task automatic run(input coa_mode_type m, input coa_op_type o, input coa_reg_type r,
                     input logic rs, input logic [7:0] a, input logic [7:0] b);
    int n;
    n = 0;
    @(posedge core_clk);
    instr_valid <= 1'b1;
    instr <= '{m, o, r, rs, a, b};
    @(posedge core_clk);
    instr_valid <= 1'b0;
    #1;
    chk({7'h00, instr_ready}, 8'h00);
    do begin
      @(posedge core_clk);
      #1;
      n++;
    end while (instr_done !== 1'b1 && n < 10);
    chk({7'h00, instr_done}, 8'h01);
    chk({7'h00, instr_ready}, 8'h01);
    chk({6'h00, instr_length}, m >= COA_DST_DIR_IMM ? 8'h03 : 8'h02);
    @(posedge core_clk);
    #1;
  endtask

  // ********************
  // scenarios
  // ********************
  task automatic t_reset();
    chk(acc, 8'h00);
    chk(index_reg, 8'h00);
    chk(stack_pointer, 8'h00);
    chk(flags, 8'h02);
  endtask

  task automatic t_src_imm();
    run(COA_SRC_IMM, COA_OP_COPY, COA_REG_ACC, 1'b0, 8'h07, 8'h00);
    run(COA_SRC_IMM, COA_OP_ADD, COA_REG_ACC, 1'b0, 8'h03, 8'h00);
    chk(acc, 8'h0a);
    run(COA_SRC_IMM, COA_OP_XOR, COA_REG_ACC, 1'b0, 8'h0f, 8'h00);
    chk(acc, 8'h05);
    run(COA_SRC_IMM, COA_OP_XOR, COA_REG_ACC, 1'b0, 8'h0f, 8'h00);
    chk(acc, 8'h0a);
    run(COA_SRC_IMM, COA_OP_COPY, COA_REG_STACK, 1'b0, 8'h33, 8'h00);
    chk(stack_pointer, 8'h33);
    chk(acc, 8'h0a);
  endtask

  task automatic t_flags_bank();
    i_mem.regs[1][8] = 8'h5a;
    i_mem.regs[0][8] = 8'ha5;
    run(COA_SRC_IMM, COA_OP_OR, COA_REG_FLAGS, 1'b0, 8'h11, 8'h00);
    run(COA_SRC_DIR, COA_OP_COPY, COA_REG_INDEX, 1'b1, 8'h08, 8'h00);
    chk(index_reg, 8'h5a);
    run(COA_SRC_IMM, COA_OP_AND, COA_REG_FLAGS, 1'b0, 8'h01, 8'h00);
    chk(flags & 8'h19, 8'h01);
    run(COA_DST_DIR_IMM, COA_OP_COPY, COA_REG_ACC, 1'b1, 8'h08, 8'h06);
    chk(i_mem.regs[0][8], 8'h06);
    chk(i_mem.regs[1][8], 8'h5a);
  endtask

  task automatic t_src_mem();
    i_mem.ram[8'h40] = 8'h21;
    i_mem.ram[8'h03] = 8'h44;
    run(COA_SRC_DIR, COA_OP_ADD, COA_REG_ACC, 1'b0, 8'h40, 8'h00);
    chk(acc, 8'h2b);
    chk(i_mem.ram[8'h40], 8'h21);
    run(COA_SRC_IMM, COA_OP_COPY, COA_REG_INDEX, 1'b0, 8'h05, 8'h00);
    run(COA_SRC_IDX, COA_OP_COPY, COA_REG_ACC, 1'b0, 8'hfe, 8'h00);
    chk(acc, 8'h44);
    chk(i_mem.ram[8'h03], 8'h44);
  endtask

  task automatic t_dst_mem();
    i_mem.ram[8'h07] = 8'h10;
    i_mem.ram[8'h15] = 8'h01;
    i_mem.ram[8'h0c] = 8'h02;
    i_mem.ram[8'h09] = 8'h04;
    run(COA_DST_DIR, COA_OP_ADD, COA_REG_ACC, 1'b0, 8'h07, 8'h00);
    chk(i_mem.ram[8'h07], 8'h54);
    chk(acc, 8'h44);
    run(COA_DST_IDX, COA_OP_ADD, COA_REG_ACC, 1'b0, 8'h10, 8'h00);
    chk(i_mem.ram[8'h15], 8'h45);
    chk(acc, 8'h44);
    run(COA_DST_IDX_IMM, COA_OP_ADD, COA_REG_ACC, 1'b0, 8'h07, 8'h05);
    chk(i_mem.ram[8'h0c], 8'h07);
    run(COA_DST_DIR_IMM, COA_OP_ADD, COA_REG_ACC, 1'b0, 8'h09, 8'h05);
    chk(i_mem.ram[8'h09], 8'h09);
    chk(acc, 8'h44);
  endtask

  initial begin
    repeat (8) @(posedge core_clk);
    sys_rst <= 1'b0;
    @(posedge core_clk);
    #1;
    t_reset();
    t_src_imm();
    t_flags_bank();
    t_src_mem();
    t_dst_mem();
    give_verdict();
  end

  // the run needs under a hundred cycles; this bound of 2000 leaves wide margin
  initial begin
    #(40 * 2000);
    failures++;
    give_verdict();
  end
endmodule
